/* File: exec_pkg.sv */
package exec_pkg;

  localparam int PC_W = 13;
  localparam int TARGET_W = 11;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int LATCH_W = 5;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic EXPIRY_RESET = 1'b1;
  localparam logic PD_RESET = 1'b1;
  localparam logic TO_ACCUMULATOR = 1'b0;
  localparam logic TO_FILE = 1'b1;

  typedef enum logic [2:0] {
    plain_nop_op = 3'h0,
    call_op = 3'h1,
    clear_file_op = 3'h2,
    clear_accumulator_op = 3'h3,
    watchdog_clear_op = 3'h4,
    complement_file_op = 3'h5,
    decrement_file_op = 3'h6,
    decrement_skip_zero_op = 3'h7
  } op_type;

  typedef enum logic [1:0] {
    exec_state = 2'b00,
    call_second_state = 2'b01,
    skip_nop_state = 2'b11
  } state_type;

  typedef struct packed {
    op_type op;
    logic [FADDR_W-1:0] file_addr;
    logic to_file;
    logic [TARGET_W-1:0] target;
  } instr_type;

  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_type;

  typedef struct packed {
    logic load;
    logic [PC_W-1:0] value;
    logic push;
    logic [PC_W-1:0] push_value;
    logic advance;
  } pc_ctrl_type;

endpackage

/* File: exec_alu.sv */
`timescale 1ns/100ps
module exec_alu
  import exec_pkg::*;
(
  input op_type op,
  input logic [DATA_W-1:0] operand,
  output logic [DATA_W-1:0] result,
  output logic result_zero
);

  always_comb begin
    unique case (op)
      complement_file_op: result = ~operand; // RULE_09
      decrement_file_op: result = operand - DATA_ONE; // RULE_11
      decrement_skip_zero_op: result = operand - DATA_ONE; // RULE_12
      clear_file_op: result = DATA_ZERO; // RULE_05
      clear_accumulator_op: result = DATA_ZERO; // RULE_06
      default: result = operand;
    endcase
    result_zero = (result == DATA_ZERO);
  end

endmodule // exec_alu

/* File: status_flags.sv */
`timescale 1ns/100ps
module status_flags
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic zero_we,
  input wire logic zero_value,
  input wire logic watchdog_set,
  input wire logic expiry_clear,
  input wire logic pd_clear,
  output logic zero_flag,
  output logic watchdog_expiry_flag,
  output logic power_down_flag
);

  logic zero_reg, zero_next;
  logic expiry_reg, expiry_next;
  logic pd_reg, pd_next;

  // Set by watchdog clear wins over a same-cycle clear
  always_comb begin
    zero_next = zero_we ? zero_value : zero_reg;
    expiry_next = watchdog_set ? 1'b1 : (expiry_clear ? 1'b0 : expiry_reg); // RULE_08
    pd_next = watchdog_set ? 1'b1 : (pd_clear ? 1'b0 : pd_reg); // RULE_08
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_reg <= ZERO_RESET;
      expiry_reg <= EXPIRY_RESET;
      pd_reg <= PD_RESET;
    end else begin
      zero_reg <= zero_next;
      expiry_reg <= expiry_next;
      pd_reg <= pd_next;
    end
  end

  assign zero_flag = zero_reg;
  assign watchdog_expiry_flag = expiry_reg;
  assign power_down_flag = pd_reg;

endmodule // status_flags

/* File: call_clear_decrement_exec.sv */
// Summary of operation
// RULE_01: Call loads its 11-bit target into instruction pointer bits 10..0.
// RULE_02: Call pushes instruction pointer plus one onto the return stack top.
// RULE_03: Call loads pointer bits 12..11 from upper latch bits 4..3.
// RULE_04: Call takes two cycles and leaves all status flags unchanged.
// RULE_05: Clear-file writes zero into the addressed register and sets zero flag.
// RULE_06: Clear-accumulator writes zero into the accumulator and sets zero flag.
// RULE_07: Watchdog clear resets the watchdog counter and its prescaler.
// RULE_08: Watchdog clear sets expiry and power-down flags, touching no other flag.
// RULE_09: Complement-file yields the inverted register and updates the zero flag.
// RULE_10: Target bit 0 sends result to accumulator, 1 to the register.
// RULE_11: Decrement-file subtracts one, writes the chosen target, updates zero flag.
// RULE_12: Decrement-skip touches no flag; a zero result discards the next instruction.
// RULE_13: The replacing no-operation cycle only advances the instruction pointer.
`timescale 1ns/100ps
module call_clear_decrement_exec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input instr_type instr,
  input wire logic [PC_W-1:0] instruction_pointer,
  input wire logic [LATCH_W-1:0] pc_upper_latch,
  input wire logic [DATA_W-1:0] file_rd_data,
  input wire logic expiry_clear,
  input wire logic pd_clear,
  output logic instr_ready,
  output file_write_type file_write,
  output pc_ctrl_type pc_ctrl,
  output logic [DATA_W-1:0] accumulator,
  output logic watchdog_clear,
  output logic zero_flag,
  output logic watchdog_expiry_flag,
  output logic power_down_flag
);

  state_type state_reg, state_next;
  file_write_type file_write_reg, file_write_next;
  pc_ctrl_type pc_ctrl_reg, pc_ctrl_next;
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic wdt_clear_reg, wdt_clear_next;
  logic ready_reg, ready_next;
  logic zero_we, zero_value, watchdog_set;
  logic [DATA_W-1:0] alu_result;
  logic alu_zero;
  logic take;
  logic [LATCH_HI-LATCH_LO:0] latch_sel;

  assign take = instr_valid && (state_reg == exec_state);
  assign latch_sel = pc_upper_latch[LATCH_HI:LATCH_LO];

  exec_alu alu_inst (
    .op(instr.op),
    .operand(file_rd_data),
    .result(alu_result),
    .result_zero(alu_zero)
  );

  status_flags flags_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .zero_we(zero_we),
    .zero_value(zero_value),
    .watchdog_set(watchdog_set),
    .expiry_clear(expiry_clear),
    .pd_clear(pd_clear),
    .zero_flag(zero_flag),
    .watchdog_expiry_flag(watchdog_expiry_flag),
    .power_down_flag(power_down_flag)
  );

  // Sequencing and result routing
  always_comb begin
    state_next = state_reg;
    file_write_next = '0;
    file_write_next.addr = instr.file_addr;
    pc_ctrl_next = '0;
    acc_next = acc_reg;
    wdt_clear_next = 1'b0;
    zero_we = 1'b0;
    zero_value = alu_zero;
    watchdog_set = 1'b0;
    unique case (state_reg)
      exec_state: begin
        if (take) begin
          unique case (instr.op)
            plain_nop_op: begin
              pc_ctrl_next.advance = 1'b1;
            end
            call_op: begin
              pc_ctrl_next.push = 1'b1; // RULE_02
              pc_ctrl_next.push_value = instruction_pointer + PC_STEP; // RULE_02
              pc_ctrl_next.load = 1'b1;
              pc_ctrl_next.value = {latch_sel, instr.target}; // RULE_01 RULE_03
              state_next = call_second_state; // RULE_04
            end
            clear_file_op: begin
              file_write_next.we = 1'b1; // RULE_05
              file_write_next.data = alu_result;
              zero_we = 1'b1;
              zero_value = 1'b1; // RULE_05
              pc_ctrl_next.advance = 1'b1;
            end
            clear_accumulator_op: begin
              acc_next = alu_result; // RULE_06
              zero_we = 1'b1;
              zero_value = 1'b1; // RULE_06
              pc_ctrl_next.advance = 1'b1;
            end
            watchdog_clear_op: begin
              wdt_clear_next = 1'b1; // RULE_07
              watchdog_set = 1'b1; // RULE_08
              pc_ctrl_next.advance = 1'b1;
            end
            complement_file_op, decrement_file_op, decrement_skip_zero_op: begin
              if (instr.to_file == TO_FILE) begin
                file_write_next.we = 1'b1; // RULE_10
                file_write_next.data = alu_result;
              end else begin
                acc_next = alu_result; // RULE_10
              end
              zero_we = (instr.op != decrement_skip_zero_op); // RULE_09 RULE_11 RULE_12
              pc_ctrl_next.advance = 1'b1;
              if (instr.op == decrement_skip_zero_op && alu_zero) begin
                state_next = skip_nop_state; // RULE_12
              end
            end
          endcase
        end
      end
      call_second_state: begin
        state_next = exec_state; // RULE_04
      end
      skip_nop_state: begin
        pc_ctrl_next.advance = 1'b1; // RULE_13
        state_next = exec_state;
      end
      default: begin
        state_next = exec_state;
      end
    endcase
    ready_next = (state_next == exec_state);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= exec_state;
      file_write_reg <= '0;
      pc_ctrl_reg <= '0;
      acc_reg <= ACC_RESET;
      wdt_clear_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      file_write_reg <= file_write_next;
      pc_ctrl_reg <= pc_ctrl_next;
      acc_reg <= acc_next;
      wdt_clear_reg <= wdt_clear_next;
      ready_reg <= ready_next;
    end
  end

  assign instr_ready = ready_reg;
  assign file_write = file_write_reg;
  assign pc_ctrl = pc_ctrl_reg;
  assign accumulator = acc_reg;
  assign watchdog_clear = wdt_clear_reg;

  // Checks
  logic take_call, take_clear_file_op, take_clear_accumulator_op, take_wdt, take_complement_file_op, take_decrement_file_op, take_skip;
  assign take_call = take && instr.op == call_op;
  assign take_clear_file_op = take && instr.op == clear_file_op;
  assign take_clear_accumulator_op = take && instr.op == clear_accumulator_op;
  assign take_wdt = take && instr.op == watchdog_clear_op;
  assign take_complement_file_op = take && instr.op == complement_file_op;
  assign take_decrement_file_op = take && instr.op == decrement_file_op;
  assign take_skip = take && instr.op == decrement_skip_zero_op;

  a_call_target_low: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    take_call |=> pc_ctrl.load && pc_ctrl.value[TARGET_W-1:0] == $past(instr.target))
    else $error("call target bits wrong");

  a_call_push_return: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    take_call |=> pc_ctrl.push && pc_ctrl.push_value == $past(instruction_pointer) + PC_STEP)
    else $error("call return address wrong");

  a_call_upper_bits: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    take_call |=> pc_ctrl.value[PC_W-1:TARGET_W] == $past(latch_sel))
    else $error("call upper bits wrong");

  a_call_two_cycles: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    take_call |=> !instr_ready ##1 instr_ready && !pc_ctrl.load && !pc_ctrl.advance)
    else $error("call not two cycles");

  a_call_flags_kept: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    take_call && !expiry_clear && !pd_clear |=> $stable(zero_flag)
      && $stable(watchdog_expiry_flag) && $stable(power_down_flag))
    else $error("call changed a flag");

  a_clear_file_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    take_clear_file_op |=> file_write.we && file_write.data == DATA_ZERO
      && file_write.addr == $past(instr.file_addr) && zero_flag)
    else $error("clear file wrong");

  a_clear_acc_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    take_clear_accumulator_op |=> accumulator == DATA_ZERO && zero_flag && !file_write.we)
    else $error("clear accumulator wrong");

  a_wdt_clear_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    take_wdt |=> watchdog_clear ##1 !watchdog_clear || take_wdt)
    else $error("watchdog clear pulse wrong");

  a_wdt_flags_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    take_wdt |=> watchdog_expiry_flag && power_down_flag && $stable(zero_flag))
    else $error("watchdog clear flags wrong");

  a_complement_dest: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    take_complement_file_op && instr.to_file == TO_ACCUMULATOR |=> !file_write.we
      && accumulator == ~$past(file_rd_data) && zero_flag == (accumulator == DATA_ZERO))
    else $error("complement to accumulator wrong");

  a_decrement_file: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    take_decrement_file_op && instr.to_file == TO_FILE |=> file_write.we && $stable(accumulator)
      && file_write.data == $past(file_rd_data) - DATA_ONE)
    else $error("decrement to file wrong");

  a_decrement_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    take_decrement_file_op && file_rd_data == DATA_ONE |=> zero_flag)
    else $error("decrement zero flag wrong");

  a_skip_flag_kept: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    take_skip |=> $stable(zero_flag))
    else $error("skip changed zero flag");

  a_skip_nop_cycle: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    take_skip && file_rd_data == DATA_ONE |=> !instr_ready ##1 instr_ready)
    else $error("skip did not discard");

  a_nop_no_effect: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
    take_skip && file_rd_data == DATA_ONE |=> ##1 pc_ctrl.advance && !file_write.we
      && !pc_ctrl.load && !pc_ctrl.push && !watchdog_clear && $stable(accumulator))
    else $error("nop cycle had side effect");

  a_call_no_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    take_call |=> !file_write.we && !watchdog_clear && $stable(accumulator))
    else $error("call had a side effect");

  a_call_slot_quiet: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    take_call |=> ##1 !file_write.we && !pc_ctrl.push && !watchdog_clear)
    else $error("call second slot not quiet");

  a_clear_file_keep: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    take_clear_file_op |=> $stable(accumulator) && pc_ctrl.advance && !pc_ctrl.load)
    else $error("clear file touched accumulator");

  a_clear_acc_adv: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    take_clear_accumulator_op |=> pc_ctrl.advance && !pc_ctrl.load && !watchdog_clear)
    else $error("clear accumulator sequencing wrong");

  a_wdt_no_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    take_wdt |=> !file_write.we && $stable(accumulator) && pc_ctrl.advance)
    else $error("watchdog clear had a side effect");

  a_complement_file: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    take_complement_file_op && instr.to_file == TO_FILE |=> file_write.we && $stable(accumulator)
      && file_write.data == ~$past(file_rd_data))
    else $error("complement to file wrong");

  a_complement_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    take_complement_file_op && file_rd_data == ~DATA_ZERO |=> zero_flag)
    else $error("complement zero flag wrong");

  a_decrement_acc: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    take_decrement_file_op && instr.to_file == TO_ACCUMULATOR |=> !file_write.we
      && accumulator == $past(file_rd_data) - DATA_ONE)
    else $error("decrement to accumulator wrong");

  a_decrement_nonzero: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    take_decrement_file_op && file_rd_data != DATA_ONE |=> !zero_flag)
    else $error("decrement nonzero flag wrong");

  a_skip_write_file: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    take_skip && instr.to_file == TO_FILE |=> file_write.we
      && file_write.data == $past(file_rd_data) - DATA_ONE)
    else $error("skip decrement result wrong");

  a_skip_no_discard: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    take_skip && file_rd_data != DATA_ONE |=> instr_ready)
    else $error("skip discarded on nonzero");

  a_skip_other_flags: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    take_skip && !expiry_clear && !pd_clear |=> $stable(watchdog_expiry_flag)
      && $stable(power_down_flag))
    else $error("skip changed a watchdog flag");

  c_call: cover property (@(posedge clk) disable iff (sys_rst) take_call ##2 take);
  c_skip_taken: cover property (@(posedge clk) disable iff (sys_rst)
    take_skip && file_rd_data == DATA_ONE);
  c_wdt_clear: cover property (@(posedge clk) disable iff (sys_rst) take_wdt);
  c_decrement_file_op_acc: cover property (@(posedge clk) disable iff (sys_rst)
    take_decrement_file_op && instr.to_file == TO_ACCUMULATOR);

endmodule // call_clear_decrement_exec

/* File: reg_file_model.sv */
`timescale 1ns/100ps
module reg_file_model
  import exec_pkg::*;
(
  input wire logic clk,
  input file_write_type file_write,
  input wire logic [FADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:127];
  // Same-cycle read of the addressed register
  assign rd_data = mem[rd_addr];
  always @(posedge clk) begin
    if (file_write.we) begin
      mem[file_write.addr] <= file_write.data;
    end
  end
endmodule // reg_file_model

/* File: test_call_clear_decrement_exec.sv */
`timescale 1ns/100ps
module test_call_clear_decrement_exec;
  import exec_pkg::*;
  logic clk = 1'b0;
  logic sys_rst, instr_valid, expiry_clear, pd_clear, instr_ready, watchdog_clear;
  logic zero_flag, watchdog_expiry_flag, power_down_flag;
  instr_type instr;
  logic [PC_W-1:0] ip;
  logic [LATCH_W-1:0] latch;
  logic [DATA_W-1:0] rd_data, accumulator;
  file_write_type file_write;
  pc_ctrl_type pc_ctrl;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  call_clear_decrement_exec call_clear_decrement_exec_inst (.clk(clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr(instr), .instruction_pointer(ip),
    .pc_upper_latch(latch), .file_rd_data(rd_data), .expiry_clear(expiry_clear),
    .pd_clear(pd_clear), .instr_ready(instr_ready), .file_write(file_write),
    .pc_ctrl(pc_ctrl), .accumulator(accumulator), .watchdog_clear(watchdog_clear),
    .zero_flag(zero_flag), .watchdog_expiry_flag(watchdog_expiry_flag),
    .power_down_flag(power_down_flag));
  reg_file_model reg_file_model_inst (.clk(clk), .file_write(file_write),
    .rd_addr(instr.file_addr), .rd_data(rd_data));

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Present one instruction and hold it to the next edge
  task automatic put(input op_type op, input logic [6:0] a, input logic tf,
                     input logic [10:0] t);
    instr_valid <= 1'b1;
    instr <= '{op, a, tf, t};
    @(posedge clk);
  endtask

  // One instruction, outputs sampled in the answer cycle
  task automatic exec(input op_type op, input logic [6:0] a, input logic tf,
                      input logic [10:0] t);
    @(posedge clk);
    put(op, a, tf, t);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk("ready", 16'h1, instr_ready);
    chk("acc", 16'h0, accumulator);
    chk("zero", 16'h0, zero_flag);
    chk("expiry", 16'h1, watchdog_expiry_flag);
    chk("pd", 16'h1, power_down_flag);
    chk("we", 16'h0, file_write.we);
    $display("reset done");
  endtask

  task automatic t_complement();
    reg_file_model_inst.mem[3] = 8'h0f;
    reg_file_model_inst.mem[4] = 8'hff;
    exec(complement_file_op, 7'h03, TO_ACCUMULATOR, 11'h000);
    chk("acc", 16'hf0, accumulator);
    chk("zero", 16'h0, zero_flag);
    chk("we", 16'h0, file_write.we);
    exec(clear_accumulator_op, 7'h00, TO_ACCUMULATOR, 11'h000);
    chk("acc", 16'h0, accumulator);
    chk("zero", 16'h1, zero_flag);
    exec(complement_file_op, 7'h04, TO_FILE, 11'h000);
    chk("wdata", 16'h0, file_write.data);
    chk("waddr", 16'h4, file_write.addr);
    $display("complement done");
  endtask

  task automatic t_call();
    latch <= 5'h17;
    exec(call_op, 7'h00, TO_ACCUMULATOR, 11'h7ff);
    chk("load", 16'h1, pc_ctrl.load);
    chk("target", 16'h17ff, pc_ctrl.value);
    chk("push", 16'h1, pc_ctrl.push);
    chk("retaddr", 16'h0abd, pc_ctrl.push_value);
    chk("ready", 16'h0, instr_ready);
    chk("zero", 16'h1, zero_flag);
    @(posedge clk);
    #1;
    chk("ready", 16'h1, instr_ready);
    chk("adv", 16'h0, pc_ctrl.advance);
    $display("call done");
  endtask

  task automatic t_clear_file();
    reg_file_model_inst.mem[127] = 8'h5a;
    exec(clear_file_op, 7'h7f, TO_ACCUMULATOR, 11'h000);
    chk("zero", 16'h1, zero_flag);
    chk("adv", 16'h1, pc_ctrl.advance);
    @(posedge clk);
    #1;
    chk("mem", 16'h0, reg_file_model_inst.mem[127]);
    $display("clear file done");
  endtask

  task automatic t_watchdog();
    @(posedge clk);
    expiry_clear <= 1'b1;
    pd_clear <= 1'b1;
    @(posedge clk);
    expiry_clear <= 1'b0;
    pd_clear <= 1'b0;
    #1;
    chk("expiry", 16'h0, watchdog_expiry_flag);
    chk("pd", 16'h0, power_down_flag);
    exec(watchdog_clear_op, 7'h00, TO_ACCUMULATOR, 11'h000);
    chk("wdclr", 16'h1, watchdog_clear);
    chk("expiry", 16'h1, watchdog_expiry_flag);
    chk("pd", 16'h1, power_down_flag);
    chk("zero", 16'h1, zero_flag);
    @(posedge clk);
    #1;
    chk("wdclr", 16'h0, watchdog_clear);
    $display("watchdog done");
  endtask

  task automatic t_decrement();
    reg_file_model_inst.mem[6] = 8'h01;
    reg_file_model_inst.mem[5] = 8'h00;
    exec(decrement_file_op, 7'h06, TO_ACCUMULATOR, 11'h000);
    chk("acc", 16'h0, accumulator);
    chk("zero", 16'h1, zero_flag);
    exec(decrement_file_op, 7'h05, TO_FILE, 11'h000);
    chk("wdata", 16'hff, file_write.data);
    chk("zero", 16'h0, zero_flag);
    $display("decrement done");
  endtask

  task automatic t_skip();
    reg_file_model_inst.mem[9] = 8'h01;
    reg_file_model_inst.mem[10] = 8'h33;
    @(posedge clk);
    put(decrement_skip_zero_op, 7'h09, TO_FILE, 11'h000);
    put(clear_file_op, 7'h0a, TO_ACCUMULATOR, 11'h000);
    instr_valid <= 1'b0;
    #1;
    chk("adv", 16'h1, pc_ctrl.advance);
    chk("we", 16'h0, file_write.we);
    chk("zero", 16'h0, zero_flag);
    @(posedge clk);
    #1;
    chk("mem9", 16'h0, reg_file_model_inst.mem[9]);
    chk("mem10", 16'h33, reg_file_model_inst.mem[10]);
    reg_file_model_inst.mem[9] = 8'h02;
    @(posedge clk);
    put(decrement_skip_zero_op, 7'h09, TO_ACCUMULATOR, 11'h000);
    put(clear_file_op, 7'h0a, TO_ACCUMULATOR, 11'h000);
    instr_valid <= 1'b0;
    #1;
    chk("acc", 16'h1, accumulator);
    chk("we", 16'h1, file_write.we);
    chk("waddr", 16'h0a, file_write.addr);
    $display("skip done");
  endtask

  initial begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    ip = 13'h0abc;
    latch = 5'h00;
    expiry_clear = 1'b0;
    pd_clear = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_complement();
    t_call();
    t_clear_file();
    t_watchdog();
    t_decrement();
    t_skip();
    conclude();
  end
endmodule // test_call_clear_decrement_exec
